/* File: logic/acbr_master.sv */
// recording master end: issues address and command, captures bus after fixed wait
`include "acbr_cfg.svh"
module acbr_master #(
    parameter int CAPT_CYC = `ACBR_CAPT_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // bus side
    acbr_bus_if.master       bus,
    // user request
    input  wire logic        start,
    input  wire logic [3:0]  chan,
    output logic             ready,
    // captured sample, every address
    output logic [9:0]       sample,
    output logic [3:0]       sample_chan,
    output logic             sample_valid,
    // passive monitor
    input  wire logic [3:0]  mon_chan,
    output logic [9:0]       mon_sample,
    output logic             mon_valid
);
    acbr_pkg::acbr_mst_state_t state_q, state_d;
    logic [17:0] cnt_q, cnt_d;
    logic [3:0]  addr_q, addr_d;
    logic        cmd_q, cmd_d;
    logic [9:0]  smp_q, smp_d;
    logic        sv_q, sv_d;
    logic [9:0]  mon_q, mon_d;
    logic        mv_q, mv_d;

    // command pulse for one cycle, then wait the fixed capture time
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        addr_d  = addr_q;
        cmd_d   = 1'b0;
        smp_d   = smp_q;
        sv_d    = 1'b0;
        mon_d   = mon_q;
        mv_d    = 1'b0;
        case (state_q)
            acbr_pkg::ACBR_M_IDLE: begin
                if (start) begin
                    addr_d  = chan;
                    cmd_d   = 1'b1;
                    cnt_d   = 18'h00000;
                    state_d = acbr_pkg::ACBR_M_WAIT;
                end
            end
            acbr_pkg::ACBR_M_WAIT: begin
                cnt_d = cnt_q + 18'h00001;
                if (cnt_q == 18'(CAPT_CYC - 1)) begin
                    smp_d   = bus.data;                      // taken whether or not anyone drove
                    sv_d    = 1'b1;
                    if (addr_q == mon_chan) begin
                        mon_d = bus.data;
                        mv_d  = 1'b1;
                    end
                    state_d = acbr_pkg::ACBR_M_IDLE;
                end
            end
            default: begin
                state_d = acbr_pkg::ACBR_M_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= acbr_pkg::ACBR_M_IDLE;
            cnt_q   <= 18'h00000;
            addr_q  <= 4'h0;
            cmd_q   <= 1'b0;
            smp_q   <= 10'h000;
            sv_q    <= 1'b0;
            mon_q   <= 10'h000;
            mv_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            addr_q  <= addr_d;
            cmd_q   <= cmd_d;
            smp_q   <= smp_d;
            sv_q    <= sv_d;
            mon_q   <= mon_d;
            mv_q    <= mv_d;
        end
    end

    assign bus.channel_addr         = addr_q;
    assign bus.conversion_command   = cmd_q;
    assign bus.conversion_command_n = ~cmd_q;
    assign ready        = (state_q == acbr_pkg::ACBR_M_IDLE);
    assign sample       = smp_q;
    assign sample_chan  = addr_q;
    assign sample_valid = sv_q;
    assign mon_sample   = mon_q;
    assign mon_valid    = mv_q;
endmodule : acbr_master

/* File: pkg/acbr_cfg.svh */
// constants for the analogue channel bus responder and its bus master
// What this block does
// - twelve channels, select by address, ten-bit output
// - decode address to sixteen low selects, invert 0-11
// - successive approximation result within twenty microseconds
// - data drivers off when address twelve or above
// - addresses twelve to fifteen served by digital inputs
// - bus: ten data, four address, one command
// - connector command is inverse of card command
// - address plus command pulse starts acquisition, enables drivers
// - valid data within 2.78 ms of command
// - receivers unaddressed; all sixteen addresses are channels
// - master captures data 2.78 ms after every command
// - monitor captures only for its chosen address
// - calibration channels give octal 200, 372, 005
// - offset binary: most significant bit is sign
`ifndef ACBR_CFG_SVH
`define ACBR_CFG_SVH
`define ACBR_DATA_W        10
`define ACBR_ADDR_W        4
`define ACBR_NUM_ANALOG    12
`define ACBR_CLK_HZ        25000000
`define ACBR_CONV_MAX_US   20
`define ACBR_CONV_CYC      ((`ACBR_CONV_MAX_US * (`ACBR_CLK_HZ / 1000000)))
`define ACBR_CAPT_US       2780
`define ACBR_CAPT_CYC      ((`ACBR_CAPT_US * (`ACBR_CLK_HZ / 1000000)))
`define ACBR_CAL_ZERO      10'h080
`define ACBR_CAL_POS       10'h0fa
`define ACBR_CAL_NEG       10'h005
`define ACBR_CH_CAL_ZERO   4'h9
`define ACBR_CH_CAL_POS    4'ha
`define ACBR_CH_CAL_NEG    4'hb
`endif

/* File: pkg/acbr_pkg.sv */
// types shared by both ends of the acquisition bus
package acbr_pkg;
    typedef enum logic [1:0] {
        ACBR_IDLE,
        ACBR_CONV,
        ACBR_HOLD
    } acbr_conv_state_t;
    typedef enum logic [1:0] {
        ACBR_M_IDLE,
        ACBR_M_WAIT,
        ACBR_M_DONE
    } acbr_mst_state_t;
endpackage : acbr_pkg

/* File: pkg/acbr_bus_if.sv */
// shared acquisition bus between the recording master and the analogue card
interface acbr_bus_if;
    logic [9:0] data_o;            // card data drive value
    logic       data_oe;           // card drives data lines
    logic [9:0] data;              // resolved data lines seen by the master
    logic [3:0] channel_addr;      // channel address from master
    logic       conversion_command;      // command pulse to the card, active high
    logic       conversion_command_n;    // connector copy, inverted
    assign data = data_oe ? data_o : 10'h000;   // resolved level; undriven reads zero
    modport card (
        input  channel_addr,
        input  conversion_command,
        output data_o,
        output data_oe
    );
    modport master (
        input  data,
        output channel_addr,
        output conversion_command,
        output conversion_command_n
    );
endinterface : acbr_bus_if

/* File: logic/acbr_card.sv */
// analogue card end: address decode, sar conversion and tristate data drive
`include "acbr_cfg.svh"
module acbr_card #(
    parameter int DATA_W   = `ACBR_DATA_W,
    parameter int CONV_CYC = `ACBR_CONV_CYC
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // bus side
    acbr_bus_if.card               bus,
    // converter comparator: high when sampled input is above trial code
    input  wire logic              comp_above,
    // analogue side
    output logic [11:0]            gate_en,
    output logic [DATA_W-1:0]      trial_code,
    output logic                   conv_busy
);
    acbr_pkg::acbr_conv_state_t state_q, state_d;
    logic [DATA_W-1:0] sar_q, sar_d;
    logic [DATA_W-1:0] bit_q, bit_d;
    logic [DATA_W-1:0] result_q, result_d;
    logic [3:0]        addr_q, addr_d;
    logic [15:0]       sel_n;
    logic              cmd_q;
    logic              cmd_rise;
    logic [15:0]       cyc_q, cyc_d;

    // command arrives from the same clock domain, so only an edge detect
    assign cmd_rise = bus.conversion_command & ~cmd_q;

    // one-of-sixteen active-low decode of the latched address
    always_comb begin
        sel_n = 16'hffff;
        sel_n[addr_q] = 1'b0;
    end
    // invert selects 0-11 into active-high gate enables
    assign gate_en = ~sel_n[11:0];

    // sar sequencer: one bit per cycle, msb first
    always_comb begin
        state_d  = state_q;
        sar_d    = sar_q;
        bit_d    = bit_q;
        result_d = result_q;
        addr_d   = addr_q;
        cyc_d    = cyc_q;
        case (state_q)
            acbr_pkg::ACBR_IDLE, acbr_pkg::ACBR_HOLD: begin
                if (cmd_rise) begin
                    addr_d  = bus.channel_addr;
                    bit_d   = {1'b1, {(DATA_W-1){1'b0}}};
                    sar_d   = {1'b1, {(DATA_W-1){1'b0}}};
                    cyc_d   = 16'h0000;
                    state_d = acbr_pkg::ACBR_CONV;
                end
            end
            acbr_pkg::ACBR_CONV: begin
                cyc_d = cyc_q + 16'h0001;
                // keep the trial bit only if the input is above it
                if (!comp_above) begin
                    sar_d = sar_q & ~bit_q;
                end
                bit_d = bit_q >> 1;
                // the cycle cap is a backstop so a stuck sequencer still ends inside the time bound
                if (bit_q[0] || (cyc_q == 16'(CONV_CYC - 1))) begin
                    result_d = comp_above ? sar_q : (sar_q & ~bit_q);   // word as found
                    state_d  = acbr_pkg::ACBR_HOLD;
                end else begin
                    sar_d = (comp_above ? sar_q : (sar_q & ~bit_q)) | (bit_q >> 1);
                end
            end
            default: begin
                state_d = acbr_pkg::ACBR_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q  <= acbr_pkg::ACBR_IDLE;
            sar_q    <= '0;
            bit_q    <= '0;
            result_q <= '0;
            addr_q   <= 4'hf;
            cyc_q    <= 16'h0000;
            cmd_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            sar_q    <= sar_d;
            bit_q    <= bit_d;
            result_q <= result_d;
            addr_q   <= addr_d;
            cyc_q    <= cyc_d;
            cmd_q    <= bus.conversion_command;
        end
    end

    assign trial_code = sar_q;
    assign conv_busy  = (state_q == acbr_pkg::ACBR_CONV);   // ten cycles, well under CONV_CYC
    assign bus.data_o = result_q;                            // held until next command
    // drivers off for addresses 12-15, left to the digital inputs
    assign bus.data_oe = (state_q == acbr_pkg::ACBR_HOLD) && !(addr_q[2] && addr_q[3]);
endmodule : acbr_card

/* File: tb/acbr_bus_checker.sv */
// assertions on the shared acquisition bus between the master and the card
`include "acbr_cfg.svh"
module acbr_bus_checker #(
    parameter int CAPT_CYC = `ACBR_CAPT_CYC
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       srst,
    // bus signals
    input wire logic [9:0] data_o,
    input wire logic       data_oe,
    input wire logic [3:0] channel_addr,
    input wire logic       conversion_command,
    input wire logic       conversion_command_n
);
    logic [17:0] idle_q;
    logic [17:0] idle_d;
    logic        hi_addr;
    // cycles since the last command, saturating; wide enough for the full capture wait
    always_comb idle_d = conversion_command ? 18'h00000 : idle_q + {17'h00000, idle_q != 18'h3ffff};
    always_ff @(posedge clk) idle_q <= srst ? 18'h3ffff : idle_d;
    assign hi_addr = channel_addr[3] & channel_addr[2];
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence quiet_s; !conversion_command [*8]; endsequence
    sequence drive_s; ##[1:14] data_oe; endsequence
    sequence off_s; !data_oe [*8]; endsequence
    cmd_inverse_a: assert property (conversion_command_n != conversion_command)
        else $error("connector command not inverted");
    cmd_pulse_a: assert property (conversion_command |=> quiet_s)
        else $error("command pulse too long");
    addr_hold_a: assert property (conversion_command |=> $stable(channel_addr) [*8])
        else $error("address moved after command");
    cmd_spacing_a: assert property (conversion_command |-> idle_q >= CAPT_CYC)
        else $error("command before capture");
    result_hold_a: assert property (idle_q >= 18'h0000d |-> $stable(data_o) && $stable(data_oe))
        else $error("result moved between commands");
    // looked at once the conversion is over, when a low address would already drive
    high_off_a: assert property (conversion_command && hi_addr |-> ##12 off_s)
        else $error("drivers on for high address");
    low_on_a: assert property (conversion_command && !hi_addr |-> drive_s)
        else $error("drivers not enabled");
    low_stay_a: assert property (conversion_command && !hi_addr |-> ##14 data_oe [*8])
        else $error("drivers dropped early");
endmodule : acbr_bus_checker

/* File: tb/acbr_tb_top.sv */
// bench joining the recording master and the analogue card over the bus
`include "acbr_cfg.svh"
module acbr_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CAPT = 40;  // short capture wait keeps the run brief
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %0t %0h %0h", $time, g, e); end end
    logic        clk = 1'b0, srst = 1'b1, start = 1'b0, comp_above = 1'b0;
    logic [3:0]  chan = 4'h0, mon_chan = 4'h0, sample_chan;
    logic        ready, sample_valid, mon_valid, conv_busy;
    logic [9:0]  sample, mon_sample, trial_code;
    logic [11:0] gate_en;
    logic [9:0]  tgt [12];
    logic [14:0] exp_q [$];
    logic [14:0] e;
    int          miscompares = 0, checked = 0, cycles = 0, busy_n = 0;
    acbr_bus_if acbr_bus_if_i ();
    acbr_card acbr_card_i (.clk(clk), .srst(srst), .bus(acbr_bus_if_i.card), .comp_above(comp_above),
        .gate_en(gate_en), .trial_code(trial_code), .conv_busy(conv_busy));
    acbr_master #(.CAPT_CYC(CAPT)) acbr_master_i (.clk(clk), .srst(srst), .bus(acbr_bus_if_i.master),
        .start(start), .chan(chan), .ready(ready), .sample(sample), .sample_chan(sample_chan),
        .sample_valid(sample_valid), .mon_chan(mon_chan), .mon_sample(mon_sample), .mon_valid(mon_valid));
    acbr_bus_checker #(.CAPT_CYC(CAPT)) acbr_bus_checker_i (.clk(clk), .srst(srst),
        .data_o(acbr_bus_if_i.data_o), .data_oe(acbr_bus_if_i.data_oe), .channel_addr(acbr_bus_if_i.channel_addr),
        .conversion_command(acbr_bus_if_i.conversion_command),
        .conversion_command_n(acbr_bus_if_i.conversion_command_n));
    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    // request one capture and note what it must return
    task automatic issue(input logic [3:0] c, input logic [3:0] m);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        start <= 1'b1;
        chan <= c;
        mon_chan <= m;
        exp_q.push_back({m == c, c, (c < 4'hc) ? tgt[c] : 10'h000});
        @(negedge clk);
        start <= 1'b0;
    endtask : issue
    initial begin : clock_gen
        forever #20 clk = ~clk;
    end
    // comparator stand-in: only the gated channel's level is seen
    always @(negedge clk) begin : comparator
        logic above;
        above = 1'b0;
        for (int i = 0; i < 12; i++) if (gate_en[i] === 1'b1) above = tgt[i] >= trial_code;
        comp_above <= above;
    end
    // oldest note against each capture, plus the hang guard; falling edge, where outputs have settled
    always @(negedge clk) begin : watcher
        cycles++;
        if (conv_busy === 1'b1) busy_n++;
        if (cycles > 6000) begin
            miscompares++;
            give_verdict();
        end else if (!srst && sample_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 15'h7fff;
            `CHK(sample, e[9:0])
            `CHK(sample_chan, e[13:10])
            `CHK(gate_en, (e[13:10] < 4'hc) ? 12'h001 << e[13:10] : 12'h000)
            `CHK(mon_valid, e[14])
            if (e[14]) `CHK(mon_sample, e[9:0])
            `CHK(busy_n, `ACBR_DATA_W)
            busy_n = 0;
        end
    end
    initial begin : main
        void'($urandom(32'h2b67));
        for (int i = 0; i < 9; i++) tgt[i] = 10'($urandom);
        tgt[9] = `ACBR_CAL_ZERO;
        tgt[10] = `ACBR_CAL_POS;
        tgt[11] = `ACBR_CAL_NEG;
        repeat (20) @(negedge clk);
        srst <= 1'b0;
        @(negedge clk);
        // calibration channels with the monitor on the positive one
        for (int c = 9; c < 12; c++) issue(4'(c), 4'ha);
        // every address back to back, the digital range included
        for (int c = 0; c < 16; c++) issue(4'(c), 4'(15 - c));
        repeat (24) issue(4'($urandom), 4'($urandom));
        repeat (CAPT + 20) @(negedge clk);
        `CHK(exp_q.size(), 0)
        give_verdict();
    end
endmodule : acbr_tb_top
